// file: logic/plp_pkg.sv
/*
  Package for the pin-level port and interrupt logic: widths, reset values,
  pin positions of the shared port and the carrier structs.
  Assumes a single clock domain and no software-visible registers.
*/
package plp_pkg;

  localparam int         CLK_DIV         = 2;          // Oscillator divided by two
  localparam int         PORTA_W         = 7;
  localparam int         PORTB_W         = 8;
  localparam int         PORTC_W         = 8;
  localparam int         PORTD_W         = 5;
  localparam logic [6:0] PORTA_DIR_RST   = 7'h00;      // All inputs after reset
  localparam logic [7:0] PORTB_DIR_RST   = 8'h00;
  localparam logic [7:0] PORTC_DIR_RST   = 8'h00;
  localparam logic       ADC_EN_RST      = 1'b0;       // Converter off after reset
  localparam int         PB_SPI_LO       = 0;
  localparam int         PB_SPI_HI       = 3;
  localparam int         PB_PWM_A        = 4;
  localparam int         PB_PWM_B        = 5;
  localparam int         PB_TIMER_COMPARE_OUT         = 6;
  localparam int         PB_TIMER_CAPTURE_IN         = 7;

  // Peripheral side of the shared port
  typedef struct packed {
    logic [3:0] spi_out;
    logic [3:0] spi_oe_n;
    logic       pulse_out_first;
    logic       pulse_out_second;
    logic       timer_compare_out;
  } plp_periph_t;

  // Interrupt pin sampling state
  typedef struct packed {
    logic               irq_meta;
    logic               irq_sync;
    logic               irq_prev;
    logic [PORTC_W-1:0] kbd_meta;
    logic [PORTC_W-1:0] kbd_sync;
    logic [PORTC_W-1:0] kbd_prev;
    logic               pending;
  } plp_irq_state_t;

endpackage

// file: logic/plp_irq_sense.sv
/*
  External interrupt sensing: synchronises the interrupt pin and the eight
  keyboard pins, detects falling edges and holds one pending request.
  Assumes the core acknowledges the request with a one-cycle pulse.
*/
`timescale 1ns/100ps
module plp_irq_sense
  import plp_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               rst_n,
  input  wire logic               ce,
  input  wire logic               irq_pin_n,
  input  wire logic [PORTC_W-1:0] kbd_pins,
  input  wire logic               level_mode,
  input  wire logic               irq_enable,
  input  wire logic               irq_ack,
  output logic                    irq_req
);

  plp_irq_state_t st_ff;
  plp_irq_state_t nxt_st;
  logic           pin_fall;
  logic           kbd_fall;
  logic           trig;

  // Edge detection looks only at the second stage of each synchroniser
  always_comb begin
    pin_fall = st_ff.irq_prev & ~st_ff.irq_sync;
    kbd_fall = |(st_ff.kbd_prev & ~st_ff.kbd_sync);
    trig     = irq_enable & (pin_fall | kbd_fall | (level_mode & ~st_ff.irq_sync));
    nxt_st          = st_ff;
    nxt_st.irq_meta = irq_pin_n;
    nxt_st.irq_sync = st_ff.irq_meta;
    nxt_st.irq_prev = st_ff.irq_sync;
    nxt_st.kbd_meta = kbd_pins;
    nxt_st.kbd_sync = st_ff.kbd_meta;
    nxt_st.kbd_prev = st_ff.kbd_sync;
    // A new event wins over an acknowledge in the same cycle
    if (trig) begin
      nxt_st.pending = 1'b1;
    end else if (irq_ack) begin
      nxt_st.pending = 1'b0;
    end
  end

  // Pins idle high, so reset them high to avoid a false edge at start
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '{irq_meta: 1'b1, irq_sync: 1'b1, irq_prev: 1'b1,
                 kbd_meta: 8'hFF, kbd_sync: 8'hFF, kbd_prev: 8'hFF, pending: 1'b0};
    end else if (ce) begin
      st_ff <= nxt_st;
    end
  end

  assign irq_req = st_ff.pending;

  a_kbd_edge_sets: assert property (@(posedge clk) disable iff (!rst_n)
    ce && irq_enable && kbd_fall |=> irq_req)
    else $error("keyboard falling edge did not set request");

  a_edge_only_mode: assert property (@(posedge clk) disable iff (!rst_n)
    ce && !irq_req && !level_mode && !pin_fall && !kbd_fall |=> !irq_req)
    else $error("request set without an edge in edge mode");

  a_level_holds: assert property (@(posedge clk) disable iff (!rst_n)
    ce && irq_enable && level_mode && !st_ff.irq_sync |=> irq_req)
    else $error("low level did not set request");

  // The edge detector must only ever see the second stage, one tick behind the first
  a_sync_delay: assert property (@(posedge clk) disable iff (!rst_n)
    rst_n && ce |=> st_ff.irq_sync == $past(st_ff.irq_meta))
    else $error("pin level skipped the synchroniser stage");

endmodule

// file: logic/plp_pin_logic.sv
/*
  Pin-level port logic: clock divider and oscillator output, reset pin
  sensing and pull-down, interrupt sensing, port direction control with
  reset defaults, shared-port muxing and analog-shared digital reads.
  Assumes the core supplies direction/data values and acknowledges.
*/
`timescale 1ns/100ps
// Overview of operation
// - The internal clock enable toggles so the operating rate is the source clock halved.
// - The oscillator output is the inverted oscillator input, forced high in stop mode.
// - A low on the reset pin, sensed by the device, resets it.
// - The reset pin is driven low while any internal reset source is active.
// - The interrupt pin is falling-edge, or falling-edge plus low-level, by a fixed option.
// - The eight keyboard pins are OR'ed into the interrupt as falling-edge sources when enabled.
// - Keyboard pin interrupts are always falling-edge, whatever the pin option.
// - All bits of the seven-bit and two eight-bit ports are inputs after reset, except port B bits taken by an enabled peripheral.
// - The converter is off after reset and the five shared pins then read digitally.
// - With the converter on, the selected channel reads 0 and the others read true.
// - Shared port bits 0-3 serial, 4-5 pulse outputs, 6 compare out, 7 capture in.
module plp_pin_logic
  import plp_pkg::*;
(
  input  wire logic               REF_CLK,
  input  wire logic               RESET_N,
  input  wire logic               CLK_EN,
  input  wire logic               OSC_IN,
  input  wire logic               STOP_MODE,
  output logic                    OSC_OUT,
  output logic                    OP_CLK_EN,
  input  wire logic               RESET_PIN_IN_N,
  output logic                    RESET_PIN_OUT,
  output logic                    RESET_PIN_OE_N,
  input  wire logic               WATCHDOG_TIMEOUT,
  input  wire logic               POWER_ON,
  input  wire logic               ILLEGAL_ADDR,
  input  wire logic               STOP_DISABLED,
  input  wire logic               LOW_VOLTAGE_TRIP,
  output logic                    CORE_RESET_N,
  input  wire logic               IRQ_PIN_N,
  input  wire logic               IRQ_LEVEL_MODE,
  input  wire logic               IRQ_ENABLE,
  input  wire logic               IRQ_ACK,
  output logic                    IRQ_REQ,
  input  wire logic               DIR_WR,
  input  wire logic [1:0]         DIR_SEL,
  input  wire logic [7:0]         DIR_DATA,
  input  wire logic [7:0]         PORTA_OUT,
  input  wire logic [7:0]         PORTB_OUT,
  input  wire logic [7:0]         PORTC_OUT,
  input  wire logic [PORTA_W-1:0] PORTA_IN,
  input  wire logic [PORTB_W-1:0] PORTB_IN,
  input  wire logic [PORTC_W-1:0] PORTC_IN,
  output logic [PORTA_W-1:0]      PORTA_PIN_OUT,
  output logic [PORTA_W-1:0]      PORTA_PIN_OE_N,
  output logic [PORTB_W-1:0]      PORTB_PIN_OUT,
  output logic [PORTB_W-1:0]      PORTB_PIN_OE_N,
  output logic [PORTC_W-1:0]      PORTC_PIN_OUT,
  output logic [PORTC_W-1:0]      PORTC_PIN_OE_N,
  input  wire plp_periph_t        PERIPH,
  input  wire logic               SPI_EN,
  input  wire logic               PWM_A_EN,
  input  wire logic               PWM_B_EN,
  input  wire logic               TIMER_COMPARE_OUT_EN,
  output logic                    TIMER_CAPTURE_IN,
  output logic [3:0]              SPI_IN,
  input  wire logic [PORTD_W-1:0] ANALOG_SHARED_INPUTS,
  input  wire logic               ADC_ENABLE_WR,
  input  wire logic               ADC_ENABLE_DATA,
  input  wire logic [2:0]         ADC_CHANNEL,
  output logic [PORTD_W-1:0]      PORTD_READ
);

  typedef struct packed {
    logic               div_ff;
    logic [PORTA_W-1:0] dira;
    logic [PORTB_W-1:0] dirb;
    logic [PORTC_W-1:0] dirc;
    logic               adc_en;
    logic [PORTD_W-1:0] pd_rd;
    logic               osc_out;
    logic               rst_meta;
    logic               rst_sync;
  } plp_top_state_t;

  plp_top_state_t st_ff;
  plp_top_state_t nxt_st;
  logic           internal_rst;
  logic [7:0]     pb_drive;
  logic [7:0]     pb_alt;

  // Decodes a direction register select; used for ports A, B and C
  function automatic logic dir_hit(input logic [1:0] sel, input logic [1:0] port);
    dir_hit = DIR_WR && (sel == port);
  endfunction

  // Any internal source pulls the pin; the sensed pin then resets the core
  always_comb begin
    internal_rst = WATCHDOG_TIMEOUT | POWER_ON | ILLEGAL_ADDR | STOP_DISABLED
                 | LOW_VOLTAGE_TRIP;
  end

  // Shared port: peripheral overrides the port latch where enabled
  always_comb begin
    pb_alt   = PORTB_OUT;
    pb_drive = ~st_ff.dirb;
    if (SPI_EN) begin
      pb_alt[PB_SPI_HI:PB_SPI_LO]   = PERIPH.spi_out;
      pb_drive[PB_SPI_HI:PB_SPI_LO] = PERIPH.spi_oe_n;
    end
    if (PWM_A_EN) begin
      pb_alt[PB_PWM_A]   = PERIPH.pulse_out_first;
      pb_drive[PB_PWM_A] = 1'b0;
    end
    if (PWM_B_EN) begin
      pb_alt[PB_PWM_B]   = PERIPH.pulse_out_second;
      pb_drive[PB_PWM_B] = 1'b0;
    end
    if (TIMER_COMPARE_OUT_EN) begin
      pb_alt[PB_TIMER_COMPARE_OUT]   = PERIPH.timer_compare_out;
      pb_drive[PB_TIMER_COMPARE_OUT] = 1'b0;
    end
  end

  // Next-state for all registered pin logic outside the interrupt sensing
  always_comb begin
    nxt_st          = st_ff;
    nxt_st.div_ff   = ~st_ff.div_ff;
    nxt_st.osc_out  = STOP_MODE ? 1'b1 : ~OSC_IN;
    nxt_st.rst_meta = RESET_PIN_IN_N;
    nxt_st.rst_sync = st_ff.rst_meta;
    if (dir_hit(DIR_SEL, 2'h0)) begin
      nxt_st.dira = DIR_DATA[PORTA_W-1:0];
    end
    if (dir_hit(DIR_SEL, 2'h1)) begin
      nxt_st.dirb = DIR_DATA;
    end
    if (dir_hit(DIR_SEL, 2'h2)) begin
      nxt_st.dirc = DIR_DATA;
    end
    if (ADC_ENABLE_WR) begin
      nxt_st.adc_en = ADC_ENABLE_DATA;
    end
    // Selected channel reads zero only while converting
    for (int i = 0; i < PORTD_W; i++) begin
      nxt_st.pd_rd[i] = ANALOG_SHARED_INPUTS[i]
                      & ~(st_ff.adc_en && (ADC_CHANNEL == 3'(i)));
    end
  end

  // Direction and converter enable return to defaults on reset
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      st_ff <= '{div_ff: 1'b0, dira: PORTA_DIR_RST, dirb: PORTB_DIR_RST,
                 dirc: PORTC_DIR_RST, adc_en: ADC_EN_RST, pd_rd: 5'h00,
                 osc_out: 1'b1, rst_meta: 1'b0, rst_sync: 1'b0};
    end else if (CLK_EN) begin
      st_ff <= nxt_st;
    end
  end

  plp_irq_sense u_irq (
    .clk        (REF_CLK),
    .rst_n      (RESET_N),
    .ce         (CLK_EN & st_ff.div_ff),
    .irq_pin_n  (IRQ_PIN_N),
    .kbd_pins   (PORTC_IN),
    .level_mode (IRQ_LEVEL_MODE),
    .irq_enable (IRQ_ENABLE),
    .irq_ack    (IRQ_ACK),
    .irq_req    (IRQ_REQ)
  );

  assign OSC_OUT          = st_ff.osc_out;
  assign OP_CLK_EN        = st_ff.div_ff;
  assign RESET_PIN_OUT    = 1'b0;
  assign RESET_PIN_OE_N   = ~internal_rst;
  assign CORE_RESET_N     = st_ff.rst_sync;
  assign PORTA_PIN_OUT    = PORTA_OUT[PORTA_W-1:0];
  assign PORTA_PIN_OE_N   = ~st_ff.dira;
  assign PORTB_PIN_OUT    = pb_alt;
  assign PORTB_PIN_OE_N   = pb_drive;
  assign PORTC_PIN_OUT    = PORTC_OUT;
  assign PORTC_PIN_OE_N   = ~st_ff.dirc;
  assign TIMER_CAPTURE_IN = PORTB_IN[PB_TIMER_CAPTURE_IN];
  assign SPI_IN           = PORTB_IN[PB_SPI_HI:PB_SPI_LO];
  assign PORTD_READ       = st_ff.pd_rd;

  a_osc_stop_high: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    CLK_EN && STOP_MODE |=> OSC_OUT)
    else $error("oscillator output not high in stop");

  a_osc_inverts: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    RESET_N && CLK_EN && !STOP_MODE |=> OSC_OUT == !$past(OSC_IN))
    else $error("oscillator output not inverted input");

  // Sampled reset in the antecedent skips the release edge, where registers are still held
  a_div_by_two: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    RESET_N && CLK_EN |=> OP_CLK_EN != $past(OP_CLK_EN))
    else $error("operating enable did not toggle");

  a_reset_pull_low: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    internal_rst |-> !RESET_PIN_OE_N && !RESET_PIN_OUT)
    else $error("reset pin not pulled on internal reset");

  a_reset_sense: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    CLK_EN && !RESET_PIN_IN_N ##1 CLK_EN |=> !CORE_RESET_N)
    else $error("low reset pin not sensed");

  a_adc_sel_zero: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    CLK_EN && st_ff.adc_en && ADC_CHANNEL == 3'h0 |=> !PORTD_READ[0])
    else $error("selected channel did not read zero");

  a_adc_off_true: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    RESET_N && CLK_EN && !st_ff.adc_en |=> PORTD_READ == $past(ANALOG_SHARED_INPUTS))
    else $error("digital read wrong with converter off");

  a_pwm_routed: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    PWM_A_EN |-> PORTB_PIN_OUT[PB_PWM_A] == PERIPH.pulse_out_first
                 && !PORTB_PIN_OE_N[PB_PWM_A])
    else $error("pulse output not routed to shared port");

endmodule

// file: tb/plp_pins_model.sv
/*
  Far-side model: oscillator source, reset pin, interrupt pin and the
  port B/C pins with external drivers and keyboard switches.
  Assumes the bench steers it through plain control inputs.
*/
`timescale 1ns/100ps
module plp_pins_model
  import plp_pkg::*;
(
  input  wire logic               REF_CLK,
  input  wire logic               osc_run,
  input  wire logic               ext_rst_low,
  input  wire logic               irq_low,
  input  wire logic [7:0]         ext_b,
  input  wire logic [7:0]         ext_c,
  input  wire logic               RESET_PIN_OUT,
  input  wire logic               RESET_PIN_OE_N,
  input  wire logic [PORTB_W-1:0] PORTB_PIN_OUT,
  input  wire logic [PORTB_W-1:0] PORTB_PIN_OE_N,
  input  wire logic [PORTC_W-1:0] PORTC_PIN_OUT,
  input  wire logic [PORTC_W-1:0] PORTC_PIN_OE_N,
  output logic                    OSC_IN,
  output logic                    RESET_PIN_IN_N,
  output logic                    IRQ_PIN_N,
  output logic [PORTB_W-1:0]      PORTB_IN,
  output logic [PORTC_W-1:0]      PORTC_IN
);
  // Source stands still when stopped; moves off the sampling edge
  initial OSC_IN = 1'b0;
  always @(negedge REF_CLK) begin
    if (osc_run) OSC_IN <= ~OSC_IN;
  end
  // Reset pin has a pull-up; an outside agent or the device may pull low
  assign RESET_PIN_IN_N = !(ext_rst_low || (!RESET_PIN_OE_N && !RESET_PIN_OUT));
  // Interrupt pin has its wire-OR pull-up
  assign IRQ_PIN_N = !irq_low;
  // Each pin shows the device drive where enabled, else the outside level
  assign PORTB_IN = (~PORTB_PIN_OE_N & PORTB_PIN_OUT) | (PORTB_PIN_OE_N & ext_b);
  assign PORTC_IN = (~PORTC_PIN_OE_N & PORTC_PIN_OUT) | (PORTC_PIN_OE_N & ext_c);
endmodule

// file: tb/plp_pin_logic_test.sv
/*
  Self-checking bench for the pin logic with random and corner stimulus.
  Assumes the far-side model and the design share port names here.
*/
`timescale 1ns/100ps
module plp_pin_logic_test;
  import plp_pkg::*;
  logic REF_CLK, RESET_N, CLK_EN, STOP_MODE, OSC_IN, OSC_OUT, OP_CLK_EN;
  logic RESET_PIN_IN_N, RESET_PIN_OUT, RESET_PIN_OE_N, CORE_RESET_N;
  logic WATCHDOG_TIMEOUT, POWER_ON, ILLEGAL_ADDR, STOP_DISABLED, LOW_VOLTAGE_TRIP;
  logic IRQ_PIN_N, IRQ_LEVEL_MODE, IRQ_ENABLE, IRQ_ACK, IRQ_REQ, DIR_WR;
  logic [1:0] DIR_SEL;
  logic [7:0] DIR_DATA, PORTA_OUT, PORTB_OUT, PORTC_OUT, PORTB_IN, PORTC_IN;
  logic [7:0] PORTB_PIN_OUT, PORTB_PIN_OE_N, PORTC_PIN_OUT, PORTC_PIN_OE_N;
  logic [6:0] PORTA_IN, PORTA_PIN_OUT, PORTA_PIN_OE_N, ea;
  plp_periph_t PERIPH;
  logic SPI_EN, PWM_A_EN, PWM_B_EN, TIMER_COMPARE_OUT_EN, TIMER_CAPTURE_IN;
  logic [3:0] SPI_IN;
  logic [4:0] ANALOG_SHARED_INPUTS, PORTD_READ, src;
  logic ADC_ENABLE_WR, ADC_ENABLE_DATA, osc_run, ext_rst_low, irq_low, p, got;
  logic [2:0] ADC_CHANNEL;
  logic [7:0] ext_b, ext_c, eb, ec, m, d, pl;
  int err_total, check_count, i, j;
  assign {WATCHDOG_TIMEOUT, POWER_ON, ILLEGAL_ADDR, STOP_DISABLED, LOW_VOLTAGE_TRIP} = src;
  plp_pin_logic i_plp_pin_logic (.*);
  plp_pins_model i_plp_pins_model (.*);
  // Free-running 125 MHz clock
  initial begin
    REF_CLK = 1'b0;
    forever #4 REF_CLK = ~REF_CLK;
  end
  task automatic chk(input logic [7:0] g, input logic [7:0] e, input string s);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("wrong value at %0t: %s got %h want %h", $time, s, g, e);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Expected port B pin drive: peripheral owners replace the latch value
  function automatic logic [7:0] bexp;
    bexp = PORTB_OUT;
    if (SPI_EN) bexp[3:0] = PERIPH.spi_out;
    if (PWM_A_EN) bexp[4] = PERIPH.pulse_out_first;
    if (PWM_B_EN) bexp[5] = PERIPH.pulse_out_second;
    if (TIMER_COMPARE_OUT_EN) bexp[6] = PERIPH.timer_compare_out;
  endfunction
  // Expected port B enables: an owning peripheral decides the drive of its bits
  function automatic logic [7:0] boe(input logic [7:0] e);
    boe = e;
    if (SPI_EN) boe[3:0] = PERIPH.spi_oe_n;
    if (PWM_A_EN) boe[4] = 1'b0;
    if (PWM_B_EN) boe[5] = 1'b0;
    if (TIMER_COMPARE_OUT_EN) boe[6] = 1'b0;
  endfunction
  // Pulls the reset pin by a source or from outside, then lets go
  task automatic rst_pin(input logic [4:0] s, input logic x);
    @(posedge REF_CLK) src <= s;
    ext_rst_low <= x;
    #1 chk({RESET_PIN_OE_N, RESET_PIN_OUT}, {s == 5'h00, 1'b0}, "pull-down");
    @(posedge REF_CLK) #1 chk(CORE_RESET_N, 1'b1, "early reset");
    @(posedge REF_CLK) #1 chk(CORE_RESET_N, 1'b0, "pin reset");
    @(posedge REF_CLK) src <= 5'h00;
    ext_rst_low <= 1'b0;
    repeat (3) @(posedge REF_CLK);
  endtask
  // Ack covers two edges so exactly one interrupt tick sees it
  task automatic ack;
    @(posedge REF_CLK) IRQ_ACK <= 1'b1;
    repeat (2) @(posedge REF_CLK);
    IRQ_ACK <= 1'b0;
  endtask
  // Any request seen within n cycles
  task automatic wait_irq(input int n);
    got = 1'b0;
    repeat (n) begin
      @(posedge REF_CLK) #1 if (IRQ_REQ === 1'b1) got = 1'b1;
    end
  endtask
  // Hang guard sized well above the planned run
  initial begin
    #160000;
    err_total++;
    print_verdict();
  end
  // Main sequence
  initial begin
    {RESET_N, STOP_MODE, IRQ_LEVEL_MODE, IRQ_ENABLE, IRQ_ACK, DIR_WR} = 6'h00;
    {SPI_EN, PWM_A_EN, PWM_B_EN, TIMER_COMPARE_OUT_EN, ADC_ENABLE_WR, ADC_ENABLE_DATA} = 6'h00;
    {DIR_SEL, DIR_DATA, PORTA_OUT, PORTB_OUT, PORTC_OUT} = 34'h0;
    {PERIPH, ANALOG_SHARED_INPUTS, ADC_CHANNEL, src, irq_low, ext_rst_low} = 26'h0;
    CLK_EN = 1'b1;
    PORTA_IN = 7'h00;
    osc_run = 1'b0;
    ext_b = 8'hFF;
    ext_c = 8'hFF;
    err_total = 0;
    check_count = 0;
    i = $urandom(32'h770A);
    repeat (2) @(posedge REF_CLK);
    #1 chk({PORTA_PIN_OE_N, CORE_RESET_N}, 8'hFE, "A dirs, core");
    chk(PORTB_PIN_OE_N & PORTC_PIN_OE_N, 8'hFF, "B C dirs");
    chk({IRQ_REQ, PORTD_READ, OSC_OUT, OP_CLK_EN}, 8'h02, "reset outs");
    @(posedge REF_CLK) RESET_N <= 1'b1;
    osc_run <= 1'b1;
    repeat (3) @(posedge REF_CLK);
    #1 p = OP_CLK_EN;
    repeat (8) begin
      @(posedge REF_CLK) #1 chk(OP_CLK_EN, !p, "halving");
      chk(OSC_OUT, !OSC_IN, "osc inv");
      p = OP_CLK_EN;
    end
    // Enable low freezes every register, the divider included
    CLK_EN <= 1'b0;
    repeat (3) @(posedge REF_CLK) #1 chk(OP_CLK_EN, p, "frozen");
    CLK_EN <= 1'b1;
    // Park the source high so that the forced stop level differs from its inverse
    @(posedge REF_CLK);
    while (!OSC_IN) @(posedge REF_CLK);
    osc_run <= 1'b0;
    STOP_MODE <= 1'b1;
    repeat (3) @(posedge REF_CLK) #1 chk(OSC_OUT, 1'b1, "stop high");
    STOP_MODE <= 1'b0;
    repeat (2) @(posedge REF_CLK);
    #1 chk(OSC_OUT, 1'b0, "stop over");
    for (i = 0; i < 5; i++) rst_pin(5'h01 << i, 1'b0);
    rst_pin(5'h00, 1'b1);
    {ea, eb, ec} = 23'h7FFFFF;
    // Back-to-back direction writes with random latches and peripherals
    @(posedge REF_CLK);
    for (i = 0; i <= 16; i++) begin
      d = $urandom;
      DIR_WR <= (i < 16);
      DIR_SEL <= (i < 4) ? i : $urandom_range(3, 0);
      DIR_DATA <= d;
      {PORTA_OUT, PORTB_OUT, PORTC_OUT, ext_b, ext_c} <= {$urandom, $urandom};
      {SPI_EN, PWM_A_EN, PWM_B_EN, TIMER_COMPARE_OUT_EN} <= $urandom;
      PERIPH <= plp_periph_t'(11'($urandom));
      #1 chk(PORTA_PIN_OE_N, ea, "A dir");
      chk(PORTB_PIN_OE_N, boe(eb), "B dir");
      chk(PORTC_PIN_OE_N, ec, "C dir");
      chk(PORTA_PIN_OUT & ~ea, PORTA_OUT[6:0] & ~ea, "A out");
      chk(PORTC_PIN_OUT & ~ec, PORTC_OUT & ~ec, "C out");
      m = ~eb | {1'b0, TIMER_COMPARE_OUT_EN, PWM_B_EN, PWM_A_EN, {4{SPI_EN}}};
      chk(PORTB_PIN_OUT & m, bexp() & m, "B mux");
      pl = (~boe(eb) & bexp()) | (boe(eb) & ext_b);
      chk({TIMER_CAPTURE_IN, SPI_IN}, {pl[7], pl[3:0]}, "B in");
      if (i < 16 && DIR_SEL == 2'd0) ea = ~d[6:0];
      if (i < 16 && DIR_SEL == 2'd1) eb = ~d;
      if (i < 16 && DIR_SEL == 2'd2) ec = ~d;
      @(posedge REF_CLK);
    end
    // Reset in mid-run: every direction written above returns to input
    RESET_N <= 1'b0;
    repeat (2) @(posedge REF_CLK);
    #1 chk({1'b1, PORTA_PIN_OE_N}, 8'hFF, "A dir reset");
    chk(PORTB_PIN_OE_N, boe(8'hFF), "B dir reset");
    chk(PORTC_PIN_OE_N, 8'hFF, "C dir reset");
    @(posedge REF_CLK) RESET_N <= 1'b1;
    repeat (2) @(posedge REF_CLK);
    // Digital reads of analog pins, converter off then on per channel
    for (i = 0; i < 16; i++) begin
      if (i == 6) begin
        ADC_ENABLE_WR <= 1'b1;
        ADC_ENABLE_DATA <= 1'b1;
        @(posedge REF_CLK) ADC_ENABLE_WR <= 1'b0;
      end
      j = i % 5;
      d = {3'h0, 5'($urandom)} | 8'h1F * (i == 7);
      ANALOG_SHARED_INPUTS <= d[4:0];
      ADC_CHANNEL <= j;
      repeat (2) @(posedge REF_CLK);
      #1 chk(PORTD_READ, (i < 6) ? d : d & ~(8'h01 << j), "analog read");
    end
    // Interrupt pin and keyboard sensing; port C all inputs, lines idle high
    DIR_WR <= 1'b1;
    DIR_SEL <= 2'd2;
    DIR_DATA <= 8'h00;
    ext_c <= 8'hFF;
    @(posedge REF_CLK) DIR_WR <= 1'b0;
    IRQ_ENABLE <= 1'b1;
    repeat (8) @(posedge REF_CLK);
    ack();
    for (i = 0; i < 2; i++) begin
      IRQ_LEVEL_MODE <= i;
      irq_low <= 1'b1;
      wait_irq(12);
      chk(got, 1'b1, "pin edge");
      ack();
      wait_irq(12);
      chk(got, i, "pin held low");
      irq_low <= 1'b0;
      repeat (8) @(posedge REF_CLK);
      ack();
      wait_irq(10);
      chk(got, 1'b0, "cleared");
    end
    for (i = 0; i < 8; i++) begin
      ext_c <= ~(8'h01 << i);
      wait_irq(12);
      chk(got, 1'b1, "key edge");
      ack();
      wait_irq(12);
      chk(got, 1'b0, "key held low");
      ext_c <= 8'hFF;
      repeat (8) @(posedge REF_CLK);
    end
    IRQ_ENABLE <= 1'b0;
    irq_low <= 1'b1;
    ext_c <= 8'h00;
    wait_irq(14);
    chk(got, 1'b0, "disabled");
    print_verdict();
  end
endmodule
